// >>> src/reader_timer_map.svh
// Register offsets, field positions, reset values and limits of the reader timer unit.
`ifndef READER_TIMER_MAP_SVH
`define READER_TIMER_MAP_SVH

// Register offsets on the 8-bit processor port.
`define ADDR_SECONDARY_STATE 6'h05
`define ADDR_COMMAND_CONTROL 6'h09
`define ADDR_COUNT_READBACK  6'h0c
`define ADDR_TICK_DIVIDER    6'h2a
`define ADDR_EVENT_SELECT    6'h2b
`define ADDR_PRELOAD_VALUE   6'h2c

// Field positions.
`define BIT_RUNNING_FLAG      7
`define BIT_START_NOW         1
`define BIT_STOP_NOW          2
`define BIT_AUTO_RELOAD       5
`define EXPONENT_MSB          4
`define BIT_START_TX_FIRST    0
`define BIT_START_TX_LAST     1
`define BIT_STOP_RX_FIRST     2
`define BIT_STOP_RX_LAST      3

// Reset values of the writable registers.
`define RESET_TICK_DIVIDER    8'h00
`define RESET_EVENT_SELECT    8'h00
`define RESET_PRELOAD_VALUE   8'h00

// Largest legal divider exponent and the prescaler width it needs.
`define EXPONENT_MAX          5'h15
`define PRESCALE_WIDTH        21

// Width of the time-slot interval.
`define SLOT_WIDTH            9

`endif

// >>> src/reader_timer_pkg.sv
// Types shared by the reader timer unit modules.
package reader_timer_pkg;

  // Run state of the main down-counter.
  typedef enum logic [0:0] {
    TIMER_STOPPED = 1'b0,
    TIMER_RUNNING = 1'b1
  } timer_run_e;

  // State of the time-slot counter.
  typedef enum logic [0:0] {
    SLOT_IDLE     = 1'b0,
    SLOT_COUNTING = 1'b1
  } slot_run_e;

  // Whole state of the prescaler.
  typedef struct packed {
    logic [20:0] cnt;
  } prescale_state_s;

  // Whole state of the time-slot counter.
  typedef struct packed {
    slot_run_e   run;
    logic [8:0]  cnt;
    logic        send;
  } slot_state_s;

  // Whole state of the timer unit.
  typedef struct packed {
    timer_run_e  run;
    logic [7:0]  count;
    logic [7:0]  divider_cfg;
    logic [7:0]  event_cfg;
    logic [7:0]  preload;
    logic        expiry;
    logic [7:0]  rdata;
  } timer_state_s;

endpackage : reader_timer_pkg

// >>> src/tick_prescaler.sv
// Power-of-two divider that makes the timer clock tick from the chip clock.
`timescale 1ns/1ns
`include "reader_timer_map.svh"

module tick_prescaler
  import reader_timer_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clear,
  input  wire logic [4:0] exponent,
  output logic            tick
);

  prescale_state_s state_reg;
  prescale_state_s state_next;
  logic [20:0]     limit;

  // Terminal count is two to the exponent minus one, exponent clamped to the legal range.
  function automatic logic [20:0] terminal_count(input logic [4:0] e);
    logic [4:0] legal;
    legal = (e > `EXPONENT_MAX) ? `EXPONENT_MAX : e;
    return 21'((21'h1 << legal) - 21'h1);
  endfunction : terminal_count

  // One tick per divided period; a clear restarts the period from zero.
  always_comb begin
    limit = terminal_count(exponent);
    tick = (state_reg.cnt == limit);
    state_next = state_reg;
    if (clear || tick) begin
      state_next.cnt = 21'h0;
    end else begin
      state_next.cnt = 21'(state_reg.cnt + 21'h1);
    end
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : tick_prescaler

// >>> src/slot_counter.sv
// Time-slot counter that requests automatic frame sends at fixed intervals.
`timescale 1ns/1ns
`include "reader_timer_map.svh"

module slot_counter
  import reader_timer_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       command_done,
  input  wire logic       encoder_tick,
  input  wire logic [8:0] slot_interval,
  input  wire logic       fifo_has_data,
  output logic            slot_send_request
);

  slot_state_s state_reg;
  slot_state_s state_next;

  // Starts after a command, counts encoder ticks, reloads on every expiry.
  always_comb begin
    state_next = state_reg;
    state_next.send = 1'b0;
    if (slot_interval == 9'h000) begin
      state_next.run = SLOT_IDLE;
    end else if (command_done) begin
      state_next.run = SLOT_COUNTING;
      state_next.cnt = slot_interval;
    end else if (state_reg.run == SLOT_COUNTING && encoder_tick) begin
      if (state_reg.cnt == 9'h000) begin
        state_next.send = fifo_has_data;
        state_next.cnt = slot_interval;
      end else begin
        state_next.cnt = 9'(state_reg.cnt - 9'h001);
      end
    end
  end

  assign slot_send_request = state_reg.send;

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '{run: SLOT_IDLE, cnt: 9'h000, send: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : slot_counter

// >>> src/reader_timer_unit.sv
// Eight-bit down-counting timer with event start/stop and time-slot send trigger.
//
// Summary of operation
// - Counter decrements each timer tick while nonzero.
// - Auto-reload loads preload instead of reaching zero.
// - Enabled start events load preload value.
// - Every start event without a stop in the same cycle retriggers the counter.
// - Enabled stop events or zero halt timer.
// - Register writes change count only at start or reload.
// - Processor stop raises no expiry request.
// - Receive stop events raise no expiry request.
// - Without stop, count to zero then flag.
// - Auto-reload raises request once per period.
// - Timer clock is chip clock over power-of-two.
// - Running flag follows start and stop events.
// - Counter value readable at address 0Ch.
// - Expiry never touches transmit or receive.
// - Command end starts slot counter if nonzero.
// - Slot expiry sends FIFO data if present.
// - Slot counter restarts on every expiry.
// - Zero slot interval disables automatic sending.
// - New slot interval used at next restart.
// - Slot interval is nine bits wide.
// - Request set on one-to-zero or one-to-reload step.
`timescale 1ns/1ns
`include "reader_timer_map.svh"

module reader_timer_unit
  import reader_timer_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       tx_first_bit_event,
  input  wire logic       tx_last_bit_event,
  input  wire logic       rx_first_bit_event,
  input  wire logic       rx_last_bit_event,
  input  wire logic       command_done,
  input  wire logic       encoder_tick,
  input  wire logic [8:0] slot_interval,
  input  wire logic       fifo_has_data,
  output logic            expiry_request_flag,
  output logic            running_flag,
  output logic [7:0]      count_readback,
  output logic            slot_send_request
);

  timer_state_s state_reg;
  timer_state_s state_next;

  logic       timer_tick;
  logic       start_event;
  logic       stop_event;
  logic       start_now_strobe;
  logic       stop_now_strobe;
  logic       auto_reload_enable;
  logic [4:0] tick_divider_exponent;
  logic [3:0] frame_events;
  logic [3:0] gated_events;

  // True when a processor access targets the given register.
  function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] target);
    return addr == target;
  endfunction : reg_hit

  // Configuration fields as seen by the counter logic.
  assign auto_reload_enable = state_reg.divider_cfg[`BIT_AUTO_RELOAD];
  assign tick_divider_exponent = state_reg.divider_cfg[`EXPONENT_MSB:0];

  // Write-only command strobes; they store nothing and read back as zero.
  assign start_now_strobe = reg_wr && reg_hit(reg_addr, `ADDR_COMMAND_CONTROL)
                            && reg_wdata[`BIT_START_NOW];
  assign stop_now_strobe = reg_wr && reg_hit(reg_addr, `ADDR_COMMAND_CONTROL)
                           && reg_wdata[`BIT_STOP_NOW];

  // Frame events in the bit order of the event selection register.
  assign frame_events = {rx_last_bit_event, rx_first_bit_event,
                         tx_last_bit_event, tx_first_bit_event};

  // Each frame event passes only when its enable bit is set.
  generate
    for (genvar i = 0; i < 4; i++) begin : g_event_gate
      assign gated_events[i] = frame_events[i] && state_reg.event_cfg[i];
    end
  endgenerate

  // Start and stop conditions combined from frame events and strobes.
  assign start_event = gated_events[`BIT_START_TX_FIRST] || gated_events[`BIT_START_TX_LAST]
                       || start_now_strobe;
  assign stop_event = gated_events[`BIT_STOP_RX_FIRST] || gated_events[`BIT_STOP_RX_LAST]
                      || stop_now_strobe;

  // Divider that turns the chip clock into the timer tick.
  tick_prescaler u_prescaler (
    .clk      (clk),
    .reset    (reset),
    .clear    (start_event),
    .exponent (tick_divider_exponent),
    .tick     (timer_tick)
  );

  // Time-slot counter for automatic quit-frame sends.
  slot_counter u_slot (
    .clk               (clk),
    .reset             (reset),
    .command_done      (command_done),
    .encoder_tick      (encoder_tick),
    .slot_interval     (slot_interval),
    .fifo_has_data     (fifo_has_data),
    .slot_send_request (slot_send_request)
  );

  // Counter, run state, register writes and read data.
  always_comb begin
    state_next = state_reg;
    state_next.expiry = 1'b0;

    // Register writes; only configuration changes, never the live count.
    if (reg_wr) begin
      if (reg_hit(reg_addr, `ADDR_TICK_DIVIDER)) begin
        state_next.divider_cfg = {2'b00, reg_wdata[5:0]};
      end
      if (reg_hit(reg_addr, `ADDR_EVENT_SELECT)) begin
        state_next.event_cfg = {4'h0, reg_wdata[3:0]};
      end
      if (reg_hit(reg_addr, `ADDR_PRELOAD_VALUE)) begin
        state_next.preload = reg_wdata;
      end
    end

    // Stop has priority over start; a stop never raises the expiry request.
    if (stop_event) begin
      state_next.run = TIMER_STOPPED;
    end else if (start_event) begin
      state_next.run = TIMER_RUNNING;
      state_next.count = state_reg.preload;
    end else if (state_reg.run == TIMER_RUNNING && timer_tick) begin
      if (state_reg.count == 8'h01 && auto_reload_enable) begin
        state_next.count = state_reg.preload;
        state_next.expiry = 1'b1;
      end else if (state_reg.count == 8'h01) begin
        state_next.count = 8'h00;
        state_next.run = TIMER_STOPPED;
        state_next.expiry = 1'b1;
      end else if (state_reg.count != 8'h00) begin
        state_next.count = 8'(state_reg.count - 8'h01);
      end else begin
        state_next.run = TIMER_STOPPED;
      end
    end

    // Registered read data; unmapped addresses read as zero.
    if (reg_rd) begin
      unique case (1'b1)
        reg_hit(reg_addr, `ADDR_SECONDARY_STATE): begin
          state_next.rdata = {(state_reg.run == TIMER_RUNNING), 7'h00};
        end
        reg_hit(reg_addr, `ADDR_COUNT_READBACK): begin
          state_next.rdata = state_reg.count;
        end
        reg_hit(reg_addr, `ADDR_TICK_DIVIDER): begin
          state_next.rdata = state_reg.divider_cfg;
        end
        reg_hit(reg_addr, `ADDR_EVENT_SELECT): begin
          state_next.rdata = state_reg.event_cfg;
        end
        reg_hit(reg_addr, `ADDR_PRELOAD_VALUE): begin
          state_next.rdata = state_reg.preload;
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end
  end

  // The timer only reports; it drives nothing into transmit or receive.
  assign expiry_request_flag = state_reg.expiry;
  assign running_flag = (state_reg.run == TIMER_RUNNING);
  assign count_readback = state_reg.count;
  assign reg_rdata = state_reg.rdata;

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '{run:         TIMER_STOPPED,
                     count:       8'h00,
                     divider_cfg: `RESET_TICK_DIVIDER,
                     event_cfg:   `RESET_EVENT_SELECT,
                     preload:     `RESET_PRELOAD_VALUE,
                     expiry:      1'b0,
                     rdata:       8'h00};
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : reader_timer_unit

// >>> dv/reader_timer_unit_sva.sv
// Port checker for the reader timer unit, bound to its top module.
`timescale 1ns/1ns
module timer_port_checker (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       expiry_request_flag,
  input wire logic       running_flag,
  input wire logic [7:0] count_readback,
  input wire logic       encoder_tick,
  input wire logic [8:0] slot_interval,
  input wire logic       fifo_has_data,
  input wire logic       slot_send_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // A write to the command register.
  wire ctl_wr = reg_wr && reg_addr == 6'h09;
  // Timer start, stop, expiry and readback relations, and slot send relations.
  a_start_runs: assert property (ctl_wr && reg_wdata[1] && !reg_wdata[2] |=> running_flag)
    else $error("start command did not run the timer.");
  a_stop_quiet: assert property (ctl_wr && reg_wdata[2] |=> !running_flag && !expiry_request_flag)
    else $error("stop command left the timer running or flagged.");
  a_expiry_from_one: assert property (expiry_request_flag |-> $past(count_readback) == 8'h01)
    else $error("expiry pulse not preceded by count one.");
  a_idle_frozen: assert property (!running_flag ##1 !running_flag |-> $stable(count_readback))
    else $error("count moved while the timer was stopped.");
  a_count_read: assert property (reg_rd && reg_addr == 6'h0c |=> reg_rdata == $past(count_readback))
    else $error("count readback register wrong.");
  a_state_read: assert property (reg_rd && reg_addr == 6'h05 |=> reg_rdata == {$past(running_flag), 7'h00})
    else $error("status register wrong.");
  a_slot_off: assert property ((slot_interval == 9'h000)[*2] |-> !slot_send_request)
    else $error("send request with zero slot interval.");
  a_send_cause: assert property (slot_send_request |-> $past(encoder_tick) && $past(fifo_has_data))
    else $error("send request without tick or data.");
  // Main scenarios reached.
  c_expiry: cover property (expiry_request_flag);
  c_send: cover property (slot_send_request);
  c_stop: cover property (ctl_wr && reg_wdata[2] && running_flag);
endmodule : timer_port_checker

bind reader_timer_unit timer_port_checker chk (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .expiry_request_flag, .running_flag, .count_readback, .encoder_tick,
  .slot_interval, .fifo_has_data, .slot_send_request);

// >>> dv/cpu_model.sv
// Processor model that reads and writes the timer registers.
`timescale 1ns/1ns
module cpu_model (
  input wire logic  clk,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_wr,
  output logic       reg_rd,
  input wire logic [7:0] reg_rdata
);
  // Bus idles with strobes low.
  initial begin
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write cycle; data is scrambled once the strobe drops.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask : wr
  // One read cycle; data is taken on the falling edge after the strobe drops.
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : cpu_model

// >>> dv/tb_reader_timer_unit.sv
// Self-checking testbench for the reader timer unit.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_reader_timer_unit;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [3:0] ev = 4'h0;
  logic       cmd_done = 1'b0;
  logic [1:0] tdiv = 2'h0;
  logic [8:0] slot = 9'h000;
  logic       fifo = 1'b0;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, rv, cnt;
  logic       wr, rd, expiry, running, send;
  int         err_total = 0;
  int         samples_checked = 0;
  int         n;
  // Chip clock and an encoder tick every fourth cycle.
  always #50 clk = ~clk;
  always @(posedge clk) tdiv <= tdiv + 2'h1;
  reader_timer_unit DUT (.clk, .reset, .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .tx_first_bit_event(ev[0]), .tx_last_bit_event(ev[1]),
    .rx_first_bit_event(ev[2]), .rx_last_bit_event(ev[3]), .command_done(cmd_done),
    .encoder_tick(tdiv == 2'h3), .slot_interval(slot), .fifo_has_data(fifo),
    .expiry_request_flag(expiry), .running_flag(running), .count_readback(cnt),
    .slot_send_request(send));
  cpu_model cpu (.clk, .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata));
  task automatic end_of_test;
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  // Counts falling edges up to the next expiry (sel 0) or send (sel 1) pulse.
  task automatic wait_pulse(input bit sel);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        err_total++;
        end_of_test();
      end
    end while ((sel ? send : expiry) !== 1'b1);
  endtask : wait_pulse
  // Drives one cycle of event pulses.
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    #1;
  endtask : pulse
  task automatic t_regs;
    logic [5:0] al [7] = '{6'h09, 6'h05, 6'h0c, 6'h2a, 6'h2b, 6'h2c, 6'h3f};
    logic [7:0] ex [7] = '{8'h00, 8'h00, 8'h00, 8'h3f, 8'h0f, 8'hff, 8'h00};
    for (int i = 0; i < 7; i++) begin
      cpu.rd(al[i], rv);
      `CHK("reset value", 8'h00, rv)
      cpu.wr(al[i], 8'hff);
      cpu.rd(al[i], rv);
      `CHK("access", ex[i], rv)
    end
  endtask : t_regs
  task automatic t_oneshot;
    for (int e = 0; e < 5; e += 2) begin
      cpu.wr(6'h2c, 8'h03);
      cpu.wr(6'h2a, 8'(e));
      cpu.wr(6'h09, 8'h02);
      `CHK("start count", 8'h03, cnt)
      `CHK("running", 1'b1, running)
      wait_pulse(1'b0);
      `CHK("ticks", (3 << e) + 1, n)
      `CHK("end count", 8'h00, cnt)
      `CHK("halted", 1'b0, running)
    end
    cpu.wr(6'h2a, 8'h00);
    cpu.wr(6'h2c, 8'h08);
    cpu.wr(6'h09, 8'h02);
    cpu.wr(6'h2c, 8'h40);
    cpu.wr(6'h2b, 8'h00);
    wait_pulse(1'b0);
    `CHK("live count kept", 5, n)
  endtask : t_oneshot
  task automatic t_auto;
    cpu.wr(6'h2c, 8'h04);
    cpu.wr(6'h2a, 8'h20);
    cpu.wr(6'h09, 8'h02);
    wait_pulse(1'b0);
    `CHK("first period", 5, n)
    `CHK("reloaded", 8'h04, cnt)
    wait_pulse(1'b0);
    `CHK("period", 4, n)
    cpu.wr(6'h09, 8'h04);
    `CHK("stopped", 1'b0, running)
  endtask : t_auto
  task automatic t_events;
    cpu.wr(6'h2c, 8'h30);
    cpu.wr(6'h2b, 8'h0f);
    pulse(4'h1);
    `CHK("tx start", 8'h30, cnt)
    repeat (5) @(posedge clk);
    pulse(4'h2);
    `CHK("retrigger", 8'h30, cnt)
    pulse(4'h4);
    rv = cnt;
    repeat (8) @(posedge clk);
    `CHK("rx stop", 1'b0, running)
    `CHK("frozen", rv, cnt)
    pulse(4'h3);
    pulse(4'h8);
    `CHK("rx end stop", 1'b0, running)
    pulse(4'h1);
    `CHK("restarted", 1'b1, running)
    pulse(4'h5);
    `CHK("stop wins", 1'b0, running)
    cpu.wr(6'h2b, 8'h00);
    pulse(4'h3);
    `CHK("disabled", 1'b0, running)
  endtask : t_events
  task automatic t_slot;
    @(posedge clk);
    slot <= 9'h002;
    fifo <= 1'b1;
    cmd_done <= 1'b1;
    @(posedge clk);
    cmd_done <= 1'b0;
    wait_pulse(1'b1);
    @(posedge clk);
    fifo <= 1'b0;
    repeat (39) begin
      @(negedge clk);
      `CHK("empty fifo", 1'b0, send)
    end
    @(posedge clk);
    fifo <= 1'b1;
    wait_pulse(1'b1);
    // A new interval is taken only at the next reload, so one more short period follows.
    @(posedge clk);
    slot <= 9'h100;
    wait_pulse(1'b1);
    `CHK("slot restart", 12, n)
    wait_pulse(1'b1);
    `CHK("nine bit gap", 1028, n)
    @(posedge clk);
    slot <= 9'h000;
    repeat (40) begin
      @(negedge clk);
      `CHK("slot off", 1'b0, send)
    end
  endtask : t_slot
  // Reset, then the scenarios in turn.
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_oneshot();
    t_auto();
    t_events();
    t_slot();
    end_of_test();
  end
endmodule : tb_reader_timer_unit
